// ==== evt_pkg.sv ====
// Purpose: shared constants of the 8-bit event timer
// Assumes: 32-bit AXI4-Lite register access, one register per aligned word
// Notes: register data sits in the low byte, upper bits read as zero
package evt_pkg;
	// register byte offsets
	localparam logic [7:0] EVT_OFS_COUNT = 8'h00; // up_counter_value
	localparam logic [7:0] EVT_OFS_CMPA = 8'h04; // compare_constant_a
	localparam logic [7:0] EVT_OFS_CMPB = 8'h08; // compare_constant_b
	localparam logic [7:0] EVT_OFS_CTRL0 = 8'h0c; // clock_clear_irq_control
	localparam logic [7:0] EVT_OFS_STAT = 8'h10; // flag_output_status
	localparam logic [7:0] EVT_OFS_CTRL1 = 8'h14; // trigger_clock_control

	// reset values and counter maximum
	localparam logic [7:0] EVT_RST_COUNT = 8'h00;
	localparam logic [7:0] EVT_RST_CMP = 8'hff;
	localparam logic [7:0] EVT_CNT_MAX = 8'hff;

	// clock_clear_irq_control fields
	localparam int EVT_C0_IEB = 7; // match_irq_enable_b
	localparam int EVT_C0_IEA = 6; // match_irq_enable_a
	localparam int EVT_C0_IEOV = 5; // overflow_irq_enable
	localparam int EVT_C0_CCLR = 3; // counter clear select, 2 bits
	localparam int EVT_C0_CKS = 0; // clock select, 3 bits

	// flag_output_status fields
	localparam int EVT_ST_MFB = 7; // match_flag_b
	localparam int EVT_ST_MFA = 6; // match_flag_a
	localparam int EVT_ST_OVF = 5; // overflow_flag
	localparam int EVT_ST_ONE = 4; // reads as one
	localparam int EVT_ST_OSB = 2; // match b output select, 2 bits
	localparam int EVT_ST_OSA = 0; // match a output select, 2 bits

	// trigger_clock_control fields
	localparam int EVT_C1_TEDGE = 3; // trigger edge select, 2 bits
	localparam int EVT_C1_TRIGGER_START_ENABLE = 2; // trigger_start_enable
	localparam int EVT_C1_ICKS = 0; // internal_prescale_sel
	localparam logic [7:0] EVT_C1_ONES = 8'he2; // bits that read as one

	// counter clear modes
	localparam logic [1:0] EVT_CLR_NONE = 2'h0;
	localparam logic [1:0] EVT_CLR_MA = 2'h1;
	localparam logic [1:0] EVT_CLR_MB = 2'h2;
	localparam logic [1:0] EVT_CLR_PIN = 2'h3;

	// output select actions
	localparam logic [1:0] EVT_OS_KEEP = 2'h0;
	localparam logic [1:0] EVT_OS_LOW = 2'h1;
	localparam logic [1:0] EVT_OS_HIGH = 2'h2;
	localparam logic [1:0] EVT_OS_TOG = 2'h3;

	// axi responses
	localparam logic [1:0] EVT_RESP_OK = 2'h0;
	localparam logic [1:0] EVT_RESP_ERR = 2'h2;
endpackage : evt_pkg

// ==== evt_timer.sv ====
// Purpose: 8-bit event timer with two compares, waveform pin and AXI4-Lite registers
// Assumes: single 10 MHz clock, synchronous active-high reset
// Notes: pins pass three flops; prescaler taps give the falling edges of clk/4..clk/128
// Operation
// R1: 8-bit up-counter, source by clock select
// R2: cpu reads and writes counter any time
// R3: wrap past maximum sets overflow flag
// R4: counter resets to zero
// R5: match a sets flag, enable a interrupts
// R6: no compare a during compare write
// R7: compare b works like compare a
// R8: both compares reset to all ones
// R9: match b interrupt gated by enable b
// R10: overflow interrupt gated by overflow enable
// R11: clear select: none, a, b, pin rise
// R12: after clear, trigger enable decides halting
// R13: select 001-011 count on prescaled falling edges
// R14: 000/100 stop; 101-111 external pin edges
// R15: trigger pin starts count, edge selectable
// R16: three interrupt sources only
// R17: two match events drive waveform pin
// R18: count stop halts counter on clear
// R19: output select: keep, low, high, toggle
// R20: flags clear by read one, write zero
// R21: trigger edge: off, rise, fall, both
// R22: trigger enable starts and halts counting
// R23: pins synchronised, edges found on clk
// R24: interrupt is level of flag and enable
`timescale 1ns/1ps
module evt_timer #(
	parameter int PRE_W = 7 // prescaler width, covers clk/128
) (
	input wire logic clk, // system clock
	input wire logic rst, // sync reset, high
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic ext_count_clock_pin, // external count clock
	input wire logic ext_counter_reset_pin, // external counter clear
	input wire logic count_trigger_pin, // count start trigger
	output logic waveform_out_pin, // compare driven output
	output logic irq_match_a, // compare a request, level
	output logic irq_match_b, // compare b request, level
	output logic irq_overflow // overflow request, level
);
	import evt_pkg::*;

	// register state
	logic [7:0] cnt_r; // up_counter_value
	logic [7:0] cmp_a_r; // compare_constant_a
	logic [7:0] cmp_b_r; // compare_constant_b
	logic [7:0] ctrl0_r; // clock_clear_irq_control
	logic [2:0] ctrl1_r; // trigger edge + trigger_start_enable
	logic icks_r; // internal_prescale_sel
	logic [3:0] os_r; // output selects b(3:2) a(1:0)
	logic flag_a_r; // match_flag_a
	logic flag_b_r; // match_flag_b
	logic flag_ov_r; // overflow_flag
	logic [2:0] armed_r; // flags read as one: b, a, ov
	logic run_r; // trigger-started run state
	logic eq_a_prev_r; // last compare a equality
	logic eq_b_prev_r; // last compare b equality
	logic [PRE_W-1:0] pre_r; // free running prescaler

	// bus state
	logic aw_held_r; // address latched
	logic w_held_r; // data latched
	logic [7:0] waddr_r; // latched write offset
	logic [7:0] wdata_r; // latched low data byte
	logic wstrb0_r; // low lane enabled

	// pin synchronisers: s1 -> s2 -> s3, filtered level
	logic [2:0] clk_s1_r, clk_s2_r, clk_s3_r; // stage per pin
	logic [2:0] pin_lvl_r; // accepted level per pin
	logic [2:0] pin_in; // raw pin bundle
	logic [2:0] pin_rise; // accepted rising edge
	logic [2:0] pin_fall; // accepted falling edge

	// decoded fields
	logic [2:0] cks; // clock select
	logic [1:0] cclr; // clear select
	logic [1:0] tedge; // trigger edge select
	logic trigger_start_enable; // trigger_start_enable
	logic wr_go; // write commits this cycle
	logic count_tick; // selected count edge
	logic count_en; // counter advances
	logic eq_a, eq_b; // raw equality
	logic sup_a, sup_b; // comparison suppressed
	logic match_a, match_b; // match events
	logic clear_evt; // counter clear event
	logic trig_evt; // trigger edge seen
	logic wr_cnt; // cpu write of counter
	logic wr_stat; // cpu write of status
	logic [7:0] rd_data; // read mux
	logic rd_ok; // read offset mapped
	logic wr_ok; // write offset mapped

	// true at the falling edge of prescaler bit k, used for all six taps
	function automatic logic presc_fall(input logic [PRE_W-1:0] pre, input logic [2:0] k);
		logic [7:0] m;
		m = (8'h01 << (k + 3'd1)) - 8'h01;
		return (pre & m[PRE_W-1:0]) == m[PRE_W-1:0];
	endfunction : presc_fall

	// offset decode shared by both bus directions
	function automatic logic ofs_mapped(input logic [7:0] a);
		return a == EVT_OFS_COUNT || a == EVT_OFS_CMPA || a == EVT_OFS_CMPB ||
			a == EVT_OFS_CTRL0 || a == EVT_OFS_STAT || a == EVT_OFS_CTRL1;
	endfunction : ofs_mapped

	assign cks = ctrl0_r[EVT_C0_CKS +: 3];
	assign cclr = ctrl0_r[EVT_C0_CCLR +: 2];
	assign tedge = ctrl1_r[2:1];
	assign trigger_start_enable = ctrl1_r[0];
	assign pin_in = {count_trigger_pin, ext_counter_reset_pin, ext_count_clock_pin};

	// three-flop synchronisers, level accepted once s2 and s3 agree
	always_ff @(posedge clk) begin
		if (rst) begin
			clk_s1_r <= 3'h0;
			clk_s2_r <= 3'h0;
			clk_s3_r <= 3'h0;
			pin_lvl_r <= 3'h0;
		end else begin
			clk_s1_r <= pin_in; // [R23]
			clk_s2_r <= clk_s1_r;
			clk_s3_r <= clk_s2_r;
			for (int i = 0; i < 3; i++) begin
				if (clk_s2_r[i] == clk_s3_r[i]) begin
					pin_lvl_r[i] <= clk_s3_r[i];
				end
			end
		end
	end
	// edges are judged against the accepted level, never stage one
	assign pin_rise = clk_s2_r & clk_s3_r & ~pin_lvl_r; // [R23]
	assign pin_fall = ~clk_s2_r & ~clk_s3_r & pin_lvl_r; // [R23]

	// free running prescaler, every tap derives from it
	always_ff @(posedge clk) begin
		if (rst) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + PRE_W'(1);
		end
	end

	// count source: taps 1,3,5 plus prescale bit pick clk/4..clk/128
	always_comb begin
		unique case (cks)
			3'h1, 3'h2, 3'h3: begin
				count_tick = presc_fall(pre_r, {cks[1:0], 1'b0} - 3'd1 + {2'h0, icks_r}); // [R13]
			end
			3'h5: count_tick = pin_rise[0]; // [R14]
			3'h6: count_tick = pin_fall[0]; // [R14]
			3'h7: count_tick = pin_rise[0] | pin_fall[0]; // [R14]
			default: count_tick = 1'b0; // 000 and 100 inhibit [R14]
		endcase
	end
	// with trigger enable off the counter free-runs on its source
	assign count_en = count_tick & (~trigger_start_enable | run_r); // [R1] [R22]

	// trigger edge select: off, rise, fall, both
	always_comb begin
		unique case (tedge)
			2'h1: trig_evt = pin_rise[2]; // [R21]
			2'h2: trig_evt = pin_fall[2]; // [R21]
			2'h3: trig_evt = pin_rise[2] | pin_fall[2]; // [R21]
			default: trig_evt = 1'b0; // trigger off [R21]
		endcase
	end

	// compares; a compare being rewritten is not looked at that cycle
	assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign sup_a = wr_go & wstrb0_r & (waddr_r == EVT_OFS_CMPA); // [R6]
	assign sup_b = wr_go & wstrb0_r & (waddr_r == EVT_OFS_CMPB); // [R7]
	assign eq_a = cnt_r == cmp_a_r;
	assign eq_b = cnt_r == cmp_b_r;
	// one event per entry into equality, so a halted counter does not retoggle
	assign match_a = eq_a & ~sup_a & ~eq_a_prev_r; // [R5]
	assign match_b = eq_b & ~sup_b & ~eq_b_prev_r; // [R7]

	// equality history, frozen while suppressed
	always_ff @(posedge clk) begin
		if (rst) begin
			eq_a_prev_r <= 1'b0;
			eq_b_prev_r <= 1'b0;
		end else begin
			eq_a_prev_r <= sup_a ? eq_a_prev_r : eq_a; // [R6]
			eq_b_prev_r <= sup_b ? eq_b_prev_r : eq_b;
		end
	end

	// clear source select
	always_comb begin
		unique case (cclr)
			EVT_CLR_MA: clear_evt = match_a; // [R11]
			EVT_CLR_MB: clear_evt = match_b; // [R11]
			EVT_CLR_PIN: clear_evt = pin_rise[1]; // [R11]
			default: clear_evt = 1'b0; // no clearing [R11]
		endcase
	end

	assign wr_cnt = wr_go & wstrb0_r & (waddr_r == EVT_OFS_COUNT);
	assign wr_stat = wr_go & wstrb0_r & (waddr_r == EVT_OFS_STAT);

	// counter: cpu write beats clear beats increment
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= EVT_RST_COUNT; // [R4]
		end else if (wr_cnt) begin
			cnt_r <= wdata_r; // [R2]
		end else if (clear_evt) begin
			cnt_r <= EVT_RST_COUNT; // [R11]
		end else if (count_en) begin
			cnt_r <= cnt_r + 8'h01; // [R1]
		end
	end

	// run state: trigger starts, any clear halts while stop mode is on
	always_ff @(posedge clk) begin
		if (rst) begin
			run_r <= 1'b0;
		end else if (!trigger_start_enable) begin
			run_r <= 1'b0; // waits for a trigger once enabled [R22]
		end else if (clear_evt) begin
			run_r <= 1'b0; // [R18] [R12]
		end else if (trig_evt) begin
			run_r <= 1'b1; // [R15] [R22]
		end
	end

	// flags: hardware set wins over the software clear
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_a_r <= 1'b0;
			flag_b_r <= 1'b0;
			flag_ov_r <= 1'b0;
		end else begin
			if (match_a) begin
				flag_a_r <= 1'b1; // [R5]
			end else if (wr_stat && armed_r[1] && !wdata_r[EVT_ST_MFA]) begin
				flag_a_r <= 1'b0; // [R20]
			end
			if (match_b) begin
				flag_b_r <= 1'b1; // [R7]
			end else if (wr_stat && armed_r[2] && !wdata_r[EVT_ST_MFB]) begin
				flag_b_r <= 1'b0; // [R20]
			end
			if (count_en && !wr_cnt && !clear_evt && cnt_r == EVT_CNT_MAX) begin
				flag_ov_r <= 1'b1; // [R3]
			end else if (wr_stat && armed_r[0] && !wdata_r[EVT_ST_OVF]) begin
				flag_ov_r <= 1'b0; // [R20]
			end
		end
	end

	// arming: a status read that saw a one allows the later zero write
	always_ff @(posedge clk) begin
		if (rst) begin
			armed_r <= 3'h0;
		end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == EVT_OFS_STAT) begin
			armed_r <= armed_r | {flag_b_r, flag_a_r, flag_ov_r}; // [R20]
		end else if (wr_stat) begin
			armed_r <= 3'h0; // one clear per read
		end
	end

	// control registers
	always_ff @(posedge clk) begin
		if (rst) begin
			cmp_a_r <= EVT_RST_CMP; // [R8]
			cmp_b_r <= EVT_RST_CMP; // [R8]
			ctrl0_r <= 8'h00;
			ctrl1_r <= 3'h0;
			icks_r <= 1'b0;
			os_r <= 4'h0;
		end else if (wr_go && wstrb0_r) begin
			unique case (waddr_r)
				EVT_OFS_CMPA: cmp_a_r <= wdata_r; // [R7]
				EVT_OFS_CMPB: cmp_b_r <= wdata_r; // [R7]
				EVT_OFS_CTRL0: ctrl0_r <= wdata_r;
				EVT_OFS_CTRL1: begin
					ctrl1_r <= wdata_r[EVT_C1_TRIGGER_START_ENABLE +: 3];
					icks_r <= wdata_r[EVT_C1_ICKS];
				end
				EVT_OFS_STAT: os_r <= wdata_r[3:0];
				default: ; // counter and unmapped handled elsewhere
			endcase
		end
	end

	// waveform pin: b before a, so b decides when both match together unless b selects keep
	always_ff @(posedge clk) begin
		if (rst) begin
			waveform_out_pin <= 1'b0;
		end else if (match_b && os_r[EVT_ST_OSB +: 2] != EVT_OS_KEEP) begin
			unique case (os_r[EVT_ST_OSB +: 2])
				EVT_OS_LOW: waveform_out_pin <= 1'b0; // [R19]
				EVT_OS_HIGH: waveform_out_pin <= 1'b1; // [R19]
				default: waveform_out_pin <= ~waveform_out_pin; // [R17]
			endcase
		end else if (match_a && os_r[EVT_ST_OSA +: 2] != EVT_OS_KEEP) begin
			unique case (os_r[EVT_ST_OSA +: 2])
				EVT_OS_LOW: waveform_out_pin <= 1'b0; // [R19]
				EVT_OS_HIGH: waveform_out_pin <= 1'b1; // [R19]
				default: waveform_out_pin <= ~waveform_out_pin; // [R17]
			endcase
		end
	end

	// three request levels, registered, one cycle behind flag and enable
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_match_a <= 1'b0;
			irq_match_b <= 1'b0;
			irq_overflow <= 1'b0;
		end else begin
			irq_match_a <= flag_a_r & ctrl0_r[EVT_C0_IEA]; // [R5] [R24] [R16]
			irq_match_b <= flag_b_r & ctrl0_r[EVT_C0_IEB]; // [R9] [R24]
			irq_overflow <= flag_ov_r & ctrl0_r[EVT_C0_IEOV]; // [R10] [R24]
		end
	end

	// write channel: address and data taken in either order
	assign wr_ok = ofs_mapped(waddr_r);
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			waddr_r <= 8'h00;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= EVT_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				waddr_r <= {s_axi_awaddr[7:2], 2'h0};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata[7:0];
				wstrb0_r <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? EVT_RESP_OK : EVT_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read mux, reserved bits as printed
	always_comb begin
		rd_ok = ofs_mapped({s_axi_araddr[7:2], 2'h0});
		unique case ({s_axi_araddr[7:2], 2'h0})
			EVT_OFS_COUNT: rd_data = cnt_r; // [R2]
			EVT_OFS_CMPA: rd_data = cmp_a_r;
			EVT_OFS_CMPB: rd_data = cmp_b_r;
			EVT_OFS_CTRL0: rd_data = ctrl0_r;
			EVT_OFS_STAT: rd_data = {flag_b_r, flag_a_r, flag_ov_r, 1'b1, os_r};
			EVT_OFS_CTRL1: rd_data = EVT_C1_ONES | {3'h0, ctrl1_r, 1'b0, icks_r};
			default: rd_data = 8'h00;
		endcase
	end

	// read channel, answer one cycle after the address is taken
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= EVT_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_data};
			s_axi_rresp <= rd_ok ? EVT_RESP_OK : EVT_RESP_ERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// checks
	AST_CNT_RST: assert property (@(posedge clk) rst |=> cnt_r == EVT_RST_COUNT) // [R4]
		else $error("counter not zero after reset");
	AST_CMP_RST: assert property (@(posedge clk) rst |=> cmp_a_r == EVT_RST_CMP && cmp_b_r == EVT_RST_CMP) // [R8]
		else $error("compares not all ones after reset");
	AST_CNT_WR: assert property (@(posedge clk) disable iff (rst) wr_cnt |=> cnt_r == $past(wdata_r)) // [R2]
		else $error("counter write lost");
	AST_MATCH_A: assert property (@(posedge clk) disable iff (rst)
		match_a ##1 1'b1 |=> irq_match_a == $past(ctrl0_r[EVT_C0_IEA])) // [R5]
		else $error("match a request wrong");
	AST_SUP_A: assert property (@(posedge clk) disable iff (rst) sup_a && !flag_a_r |=> !flag_a_r) // [R6]
		else $error("compare a looked at during its write");
	AST_IRQ_B: assert property (@(posedge clk) disable iff (rst) !ctrl0_r[EVT_C0_IEB] |=> !irq_match_b) // [R9]
		else $error("match b request without enable");
	AST_IRQ_OV: assert property (@(posedge clk) disable iff (rst) flag_ov_r && ctrl0_r[EVT_C0_IEOV] |=> irq_overflow) // [R10]
		else $error("overflow request missing");
	AST_OVF: assert property (@(posedge clk) disable iff (rst)
		count_en && !wr_cnt && !clear_evt && cnt_r == EVT_CNT_MAX |=> flag_ov_r && cnt_r == 8'h00) // [R3]
		else $error("wrap did not set overflow");
	AST_INHIBIT: assert property (@(posedge clk) disable iff (rst)
		(cks == 3'h0 || cks == 3'h4) && !wr_cnt && !clear_evt |=> $stable(cnt_r)) // [R14]
		else $error("counter moved while inhibited");
	AST_CLR_A: assert property (@(posedge clk) disable iff (rst) cclr == EVT_CLR_MA && match_a && !wr_cnt |=> cnt_r == 8'h00) // [R11]
		else $error("match a clear missed");
	AST_HALT: assert property (@(posedge clk) disable iff (rst) trigger_start_enable && clear_evt |=> !run_r) // [R18]
		else $error("count stop did not halt");
	AST_OUT_LOW: assert property (@(posedge clk) disable iff (rst)
		match_a && os_r[1:0] == EVT_OS_LOW && !match_b |=> !waveform_out_pin) // [R19]
		else $error("output select low ignored");
	AST_FLAG_SRC: assert property (@(posedge clk) disable iff (rst) $rose(flag_a_r) |-> $past(match_a)) // [R5]
		else $error("match flag a set without match");
	COV_OVF: cover property (@(posedge clk) disable iff (rst) $rose(flag_ov_r));
	COV_CLR_B: cover property (@(posedge clk) disable iff (rst) cclr == EVT_CLR_MB && match_b);
	COV_TRIG: cover property (@(posedge clk) disable iff (rst) trigger_start_enable && trig_evt ##1 run_r);
	COV_TOGGLE: cover property (@(posedge clk) disable iff (rst) match_a && os_r[1:0] == EVT_OS_TOG);
endmodule : evt_timer

// ==== evt_pins.sv ====
// Purpose: far-side model that drives the timer's three input pins
// Assumes: the bench asks for one toggle of a pin at a time
// Notes: levels move on a clock edge and stay put until the next request
`timescale 1ns/1ps
module evt_pins (
	input wire logic clk, // system clock
	input wire logic rst, // sync reset, high
	input wire logic [2:0] tog, // toggle request per pin
	output logic ext_count_clock_pin, // external count clock
	output logic ext_counter_reset_pin, // external counter clear
	output logic count_trigger_pin // count start trigger
);
	// pins idle low; requests come five cycles apart so each level outlasts the input filter
	always_ff @(posedge clk) begin
		if (rst) begin
			ext_count_clock_pin <= 1'b0;
			ext_counter_reset_pin <= 1'b0;
			count_trigger_pin <= 1'b0;
		end else begin
			ext_count_clock_pin <= ext_count_clock_pin ^ tog[0];
			ext_counter_reset_pin <= ext_counter_reset_pin ^ tog[1];
			count_trigger_pin <= count_trigger_pin ^ tog[2];
		end
	end
endmodule : evt_pins

// ==== tb_top.sv ====
// Purpose: self-checking bench for the 8-bit event timer
// Assumes: axi4-lite master tasks here, input pins driven by evt_pins
// Notes: prescaled counts are taken over a window, one count of slack for phase
`timescale 1ns/1ps
module tb_top;
	import evt_pkg::*;
	localparam logic [31:0] RST_TAB [7] = '{32'h00, 32'hff, 32'hff, 32'h00, 32'h10, 32'he2, 32'h00};
	localparam logic [7:0] OS_TAB [7] = '{8'h2, 8'h0, 8'h3, 8'h3, 8'h1, 8'h2, 8'h1};
	localparam logic [7:0] TRG_TAB [7] = '{8'h1, 8'h2, 8'h2, 8'h1, 8'h3, 8'h3, 8'h0};
	localparam logic [7:0] TRG_GO [7] = '{8'h1, 8'h1, 8'h0, 8'h0, 8'h1, 8'h1, 8'h0};
	localparam logic [7:0] OSB_TAB [3] = '{8'h08, 8'h04, 8'h0c};
	logic clk = 1'b0; // 10 mhz clock
	logic rst = 1'b1; // sync reset
	logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0; // bus payloads
	logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0; // master handshakes
	logic awr, wrdy, bv, arr, rv; // slave handshakes
	logic [1:0] br, rr; // responses
	logic [31:0] rdq; // read data
	logic [2:0] tog = 3'h0; // pin toggle requests
	logic xclk, xrst, trg, wf, ia, ib, iov; // pins and requests
	logic [31:0] seed = 32'h00013a66; // xorshift state
	logic [31:0] d; // scratch read value
	logic wf_e; // expected waveform level
	int error_cnt = 0;
	int comparisons = 0;
	always #50 clk = ~clk; // 100 ns period
	evt_timer i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdq), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .ext_count_clock_pin(xclk),
		.ext_counter_reset_pin(xrst), .count_trigger_pin(trg), .waveform_out_pin(wf), .irq_match_a(ia),
		.irq_match_b(ib), .irq_overflow(iov));
	evt_pins i_pins (.clk(clk), .rst(rst), .tog(tog), .ext_count_clock_pin(xclk),
		.ext_counter_reset_pin(xrst), .count_trigger_pin(trg));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// counts expected in a 128-cycle window
	function automatic logic [7:0] pre_exp(input int c, input int k);
		if (c == 0 || c == 4) return 8'h00;
		return 8'(128 >> (2 * c + k));
	endfunction : pre_exp
	function automatic logic wf_next(input logic [1:0] c, input logic w);
		return (c == EVT_OS_LOW) ? 1'b0 : (c == EVT_OS_HIGH) ? 1'b1 : (c == EVT_OS_TOG) ? ~w : w;
	endfunction : wf_next
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one write; address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic dn;
		dn = 1'b0;
		awa <= {24'h0, a};
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (int n = 0; n < 40 && !dn; n++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
			if (bv) begin
				dn = 1'b1;
				bry <= 1'b0;
				chk("bresp", 32'((a > EVT_OFS_CTRL1) ? EVT_RESP_ERR : EVT_RESP_OK), 32'(br));
			end
		end
		if (!dn) chk("bvalid", 32'h1, 32'h0);
		@(posedge clk); // spare edge so the next call never re-drives in this step
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic dn;
		dn = 1'b0;
		q = 32'h0;
		ara <= {24'h0, a};
		arv <= 1'b1;
		rry <= 1'b1;
		for (int n = 0; n < 40 && !dn; n++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) begin
				dn = 1'b1;
				rry <= 1'b0;
				q = rdq;
				chk("rresp", 32'((a > EVT_OFS_CTRL1) ? EVT_RESP_ERR : EVT_RESP_OK), 32'(rr));
			end
		end
		if (!dn) chk("rvalid", 32'h1, 32'h0);
		@(posedge clk);
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		rd(a, q);
		chk($sformatf("reg %h", a), e, q);
	endtask : rdc
	// one pin toggle, then four cycles of hold
	task automatic pulse(input int k);
		tog[k] <= 1'b1;
		@(posedge clk);
		tog[k] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulse
	task automatic ext_rise(input int n);
		repeat (n) begin
			pulse(0);
			pulse(0);
		end
		repeat (6) @(posedge clk); // let the last edge pass the filter
	endtask : ext_rise
	task automatic wrap_up();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	// watchdog, well beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
	initial begin
		logic [31:0] q0, q1;
		logic [7:0] v, e;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 7; i++) rdc(8'(4 * i), RST_TAB[i]);
		// random register traffic while the counter is stopped
		for (int i = 0; i < 8; i++) begin
			v = 8'(rnd());
			wr(8'(4 * (i % 3)), v);
			rdc(8'(4 * (i % 3)), {24'h0, v});
		end
		// every internal and stopped clock select
		for (int i = 0; i < 10; i++) begin
			wr(EVT_OFS_CTRL1, 8'(i % 2));
			wr(EVT_OFS_CTRL0, 8'(i / 2));
			wr(EVT_OFS_COUNT, 8'(rnd()));
			rd(EVT_OFS_COUNT, q0);
			repeat (128) @(posedge clk);
			rd(EVT_OFS_COUNT, q1);
			e = pre_exp(i / 2, i % 2);
			q1 = 32'(8'(q1[7:0] - q0[7:0]));
			if (e != 8'h00 && q1 === 32'(e) + 32'h1) q1 = 32'(e);
			chk("prescale", 32'(e), q1);
		end
		for (int i = 5; i < 8; i++) begin
			wr(EVT_OFS_CTRL0, 8'(i));
			wr(EVT_OFS_COUNT, 8'h00);
			ext_rise(4);
			rdc(EVT_OFS_COUNT, (i == 7) ? 32'h8 : 32'h4);
		end
		// clear on match a with each output action
		wr(EVT_OFS_CMPA, 8'h03);
		wr(EVT_OFS_CMPB, 8'hff);
		wr(EVT_OFS_CTRL0, 8'h0d);
		wf_e = 1'b0;
		for (int i = 0; i < 7; i++) begin
			wr(EVT_OFS_STAT, OS_TAB[i]);
			wr(EVT_OFS_COUNT, 8'h00);
			ext_rise(3);
			wf_e = wf_next(OS_TAB[i][1:0], wf_e);
			chk("waveform a", 32'(wf_e), 32'(wf));
			rdc(EVT_OFS_COUNT, 32'h0);
		end
		// match b drives high, low, toggle; no clear first, then clear on b
		wr(EVT_OFS_CMPA, 8'hff);
		wr(EVT_OFS_CMPB, 8'h03);
		for (int i = 0; i < 3; i++) begin
			wr(EVT_OFS_STAT, OSB_TAB[i]);
			wr(EVT_OFS_CTRL0, (i == 0) ? 8'h85 : 8'h95);
			wr(EVT_OFS_COUNT, 8'h00);
			ext_rise(3);
			wf_e = wf_next(OSB_TAB[i][3:2], wf_e);
			chk("waveform b", 32'(wf_e), 32'(wf));
			rdc(EVT_OFS_COUNT, (i == 0) ? 32'h3 : 32'h0);
		end
		chk("irq b", 32'h1, 32'(ib));
		wr(EVT_OFS_CTRL0, 8'h05);
		chk("irq b off", 32'h0, 32'(ib));
		chk("irq a off", 32'h0, 32'(ia));
		rd(EVT_OFS_STAT, d);
		chk("match flags", 32'h3, 32'(d[7:6]));
		wr(EVT_OFS_CTRL0, 8'h45);
		chk("irq a", 32'h1, 32'(ia));
		wr(EVT_OFS_STAT, 8'h00);
		rd(EVT_OFS_STAT, d);
		chk("flags cleared", 32'h0, 32'(d[7:5]));
		chk("irq a cleared", 32'h0, 32'(ia));
		// wrap from fe through ff
		wr(EVT_OFS_CTRL0, 8'h25);
		wr(EVT_OFS_COUNT, 8'hfe);
		ext_rise(2);
		rdc(EVT_OFS_COUNT, 32'h0);
		rd(EVT_OFS_STAT, d);
		chk("overflow", 32'h1, 32'(d[5]));
		chk("irq ovf", 32'h1, 32'(iov));
		wr(EVT_OFS_CTRL0, 8'h05);
		chk("irq ovf off", 32'h0, 32'(iov));
		// clear by the reset pin
		wr(EVT_OFS_CTRL0, 8'h1d);
		wr(EVT_OFS_COUNT, 8'h07);
		pulse(1);
		pulse(1);
		rdc(EVT_OFS_COUNT, 32'h0);
		// trigger start with each edge code, halt when match a clears
		wr(EVT_OFS_CMPA, 8'h02);
		wr(EVT_OFS_CTRL0, 8'h0d);
		wr(EVT_OFS_CTRL1, 8'h04);
		wr(EVT_OFS_COUNT, 8'h00);
		for (int i = 0; i < 7; i++) begin
			wr(EVT_OFS_CTRL1, 8'((TRG_TAB[i] << 3) | 8'h04));
			pulse(2);
			ext_rise(1);
			rdc(EVT_OFS_COUNT, 32'(TRG_GO[i]));
			ext_rise(2);
			rdc(EVT_OFS_COUNT, 32'h0);
		end
		// mid-run reset, waveform left high by match b
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 7; i++) rdc(8'(4 * i), RST_TAB[i]);
		chk("waveform rst", 32'h0, 32'(wf));
		wrap_up();
	end
endmodule : tb_top
